/* src/tsc_pkg.sv */
// Purpose: Shared constants for the thermal sense conversion controller.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes:   Offsets are byte addresses inside the block; field positions are bit numbers.
`default_nettype none
package tsc_pkg;
  localparam int          TSC_AW              = 5;
  localparam logic [4:0]  TSC_OFF_CLK         = 5'h00;
  localparam logic [4:0]  TSC_OFF_CTL         = 5'h04;
  localparam logic [4:0]  TSC_OFF_TIME        = 5'h08;
  localparam logic [4:0]  TSC_OFF_STAT        = 5'h0C;
  localparam logic [4:0]  TSC_OFF_RSLT        = 5'h10;
  localparam logic [4:0]  TSC_OFF_IFLG        = 5'h14;
  localparam logic [4:0]  TSC_OFF_ICLR        = 5'h18;
  localparam logic [4:0]  TSC_OFF_IEN         = 5'h1C;
  // Clock register fields.
  localparam int          TSC_CLK_SRC_LSB     = 0;
  localparam int          TSC_CLK_DIV_LSB     = 2;
  localparam int          TSC_CLK_GATE_BIT    = 4;
  // Control register fields.
  localparam int          TSC_CTL_TRIG_BIT    = 0;
  localparam int          TSC_CTL_SENSOR_BIT  = 1;
  // Status register fields.
  localparam int          TSC_STAT_BUSY_BIT   = 0;
  localparam int          TSC_STAT_VALID_BIT  = 1;
  // Interrupt status bits.
  localparam int          TSC_IRQ_DONE_BIT    = 0;
  localparam int          TSC_IRQ_W           = 1;
  // Clock source codes.
  localparam logic [1:0]  TSC_SRC_FAST_B      = 2'h0;
  localparam logic [1:0]  TSC_SRC_SLOW        = 2'h1;
  localparam logic [1:0]  TSC_SRC_FAST_A      = 2'h2;
  localparam logic [1:0]  TSC_SRC_RESERVED    = 2'h3;
  localparam logic [1:0]  TSC_DIV_RST         = 2'h0;
  localparam logic [7:0]  TSC_PERIOD_RST      = 8'h00;
  localparam logic [7:0]  TSC_CODE_ZERO       = 8'h00;
  localparam logic [7:0]  TSC_CODE_LAST       = 8'hFF;
  localparam logic [2:0]  TSC_DIV_ONES        = 3'h7;
  localparam logic [1:0]  TSC_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  TSC_RESP_SLVERR     = 2'h2;
  localparam logic [31:0] TSC_ZERO32          = 32'h0000_0000;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b00,
    TSC_ARM  = 2'b01,
    TSC_STEP = 2'b10
  } tsc_state_e;
endpackage : tsc_pkg
`default_nettype wire

/* src/tsc_top.sv */
// Purpose: Thermal sense conversion controller with AXI4-Lite registers.
// Assumes: Oscillator inputs are synchronous enables in the aclk domain,
//          each high for one aclk cycle per oscillator edge.
// Notes:   The operating clock is a tick enable, never a derived clock.
//
// Behaviour
// - The two-bit source field picks fast B, slow, fast A, or reserved, default fast B.
// - With the slow oscillator selected its ticks pass undivided and the divider is ignored.
// - With a fast oscillator selected the divider field divides by 1, 2, 4 or 8.
// - The gate enable, reset to 0, stops the operating clock while 0.
// - Each conversion starts at code zero and steps up once per period, at most 256 steps.
// - On a comparator match the current code is latched as result and conversion halts.
// - Latching the result raises a completion interrupt event.
// - Each step lasts period setting plus one operating clock cycles.
// - Busy reads 1 during conversion, set within one operating clock of the trigger.
// - Writing 0 to the trigger during conversion aborts it and marks the result invalid.
// - No conversion starts by itself; each needs a new write of 1 to the trigger.
`default_nettype none
module tsc_top
  import tsc_pkg::*;
#(
  parameter int CODE_W = 8
) (
  // Clock, reset and freeze.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // Oscillator ticks.
  input  wire logic              fast_osc_a,
  input  wire logic              fast_osc_b,
  input  wire logic              slow_osc_32k,
  // Analog sensor and comparator.
  input  wire logic              cmp_match,
  output logic                   sensor_power_on,
  output logic [CODE_W-1:0]      cmp_code,
  // AXI4-Lite write address.
  input  wire logic [TSC_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [TSC_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Interrupt.
  output logic                   irq
);

  logic [1:0]          thermal_clk_source_sel;
  logic [1:0]          thermal_clk_divider_sel;
  logic                thermal_clk_gate_en;
  logic [7:0]          step_compare_period;
  logic                conversion_trigger;
  logic                conversion_busy_flag;
  logic                result_valid;
  logic [CODE_W-1:0]   result_code;
  logic [TSC_IRQ_W-1:0] irq_status;
  logic [TSC_IRQ_W-1:0] irq_enable;
  tsc_state_e          state;
  logic [7:0]          step_cnt;
  logic [2:0]          div_cnt;
  logic                thermal_op_clock;
  logic                src_tick;
  logic [2:0]          div_mask;
  logic                done_evt;
  logic [TSC_AW-1:0]   aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                aw_held;
  logic                w_held;
  logic                wr_go;
  logic                trig_set;
  logic                trig_clr;
  logic                wr_clk;
  logic                wr_ctl;
  logic                wr_time;
  logic                wr_iclr;
  logic                wr_ien;
  logic [TSC_IRQ_W-1:0] irq_evt;
  logic [31:0]         next_rdata;
  logic [1:0]          next_rresp;

  function automatic logic hit(input logic [TSC_AW-1:0] a, input logic [TSC_AW-1:0] off);
    hit = (a == off);
  endfunction

  // Source mux; the reserved code yields no ticks at all.
  always_comb begin
    case (thermal_clk_source_sel)
      TSC_SRC_FAST_B: src_tick = fast_osc_b;
      TSC_SRC_SLOW:   src_tick = slow_osc_32k;
      TSC_SRC_FAST_A: src_tick = fast_osc_a;
      default:        src_tick = 1'b0;
    endcase
    div_mask = TSC_DIV_ONES >> (3'd3 - {1'b0, thermal_clk_divider_sel});
  end

  // Divider counts source ticks; the slow source bypasses it.
  // Counting enables in the aclk domain avoids a derived clock, at the cost
  // that a source faster than aclk cannot be represented.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt          <= 3'h0;
      thermal_op_clock <= 1'b0;
    end else if (clk_en) begin
      thermal_op_clock <= 1'b0;
      if (!thermal_clk_gate_en) begin
        div_cnt <= 3'h0;
      end else if (src_tick) begin
        if (thermal_clk_source_sel == TSC_SRC_SLOW) begin
          thermal_op_clock <= 1'b1;
        end else if ((div_cnt & div_mask) == div_mask) begin
          div_cnt          <= 3'h0;
          thermal_op_clock <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end

  // AXI4-Lite write side: address and data are held until both are present.
  // Lane zero must be strobed, since the upper lanes hold no fields.
  assign wr_go    = aw_held && w_held && !s_axi_bvalid;
  assign wr_clk   = wr_go && w_strb[0] && hit(aw_addr, TSC_OFF_CLK);
  assign wr_ctl   = wr_go && w_strb[0] && hit(aw_addr, TSC_OFF_CTL);
  assign wr_time  = wr_go && w_strb[0] && hit(aw_addr, TSC_OFF_TIME);
  assign wr_iclr  = wr_go && w_strb[0] && hit(aw_addr, TSC_OFF_ICLR);
  assign wr_ien   = wr_go && w_strb[0] && hit(aw_addr, TSC_OFF_IEN);
  // Any control write with the trigger bit low aborts, even when idle.
  assign trig_set = wr_ctl && w_data[TSC_CTL_TRIG_BIT];
  assign trig_clr = wr_ctl && !w_data[TSC_CTL_TRIG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= TSC_ZERO32;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TSC_RESP_OKAY;
    end else if (clk_en) begin
      // Ready pulses for one cycle, so a held address is never overwritten.
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unaligned or out-of-map writes answer with an error and change nothing.
        s_axi_bresp  <= (aw_addr[1:0] == 2'b00 && aw_addr <= TSC_OFF_IEN) ?
                        TSC_RESP_OKAY : TSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-owned configuration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_clk_source_sel  <= TSC_SRC_FAST_B;
      thermal_clk_divider_sel <= TSC_DIV_RST;
      thermal_clk_gate_en     <= 1'b0;
      step_compare_period     <= TSC_PERIOD_RST;
      sensor_power_on         <= 1'b0;
      irq_enable              <= '0;
    end else if (clk_en) begin
      if (wr_clk) begin
        thermal_clk_source_sel  <= w_data[TSC_CLK_SRC_LSB +: 2];
        thermal_clk_divider_sel <= w_data[TSC_CLK_DIV_LSB +: 2];
        thermal_clk_gate_en     <= w_data[TSC_CLK_GATE_BIT];
      end
      if (wr_ctl) begin
        sensor_power_on <= w_data[TSC_CTL_SENSOR_BIT];
      end
      if (wr_time) begin
        step_compare_period <= w_data[7:0];
      end
      if (wr_ien) begin
        irq_enable <= w_data[TSC_IRQ_W-1:0];
      end
    end
  end

  // Conversion sequencer: pending trigger, arm on a tick, then step.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                <= TSC_IDLE;
      conversion_trigger   <= 1'b0;
      conversion_busy_flag <= 1'b0;
      result_valid         <= 1'b0;
      result_code          <= '0;
      cmp_code             <= '0;
      step_cnt             <= TSC_PERIOD_RST;
      done_evt             <= 1'b0;
    end else if (clk_en) begin
      done_evt <= 1'b0;
      if (trig_clr) begin
        // An abort keeps cmp_code but drops the valid flag, so software never trusts it.
        state                <= TSC_IDLE;
        conversion_trigger   <= 1'b0;
        conversion_busy_flag <= 1'b0;
        result_valid         <= 1'b0;
      end else if (trig_set && state == TSC_IDLE) begin
        state              <= TSC_ARM;
        conversion_trigger <= 1'b1;
        result_valid       <= 1'b0;
      end else if (thermal_op_clock) begin
        case (state)
          // The first tick only arms, so busy rises within one operating clock.
          TSC_ARM: begin
            state                <= TSC_STEP;
            conversion_busy_flag <= 1'b1;
            cmp_code             <= TSC_CODE_ZERO;
            step_cnt             <= step_compare_period;
          end
          TSC_STEP: begin
            if (step_cnt != TSC_PERIOD_RST) begin
              step_cnt <= step_cnt - 8'h01;
            end else if (cmp_match || cmp_code == TSC_CODE_LAST) begin
              // The code keeps its value afterwards, so the final level stays visible.
              result_code          <= cmp_code;
              result_valid         <= 1'b1;
              done_evt             <= 1'b1;
              conversion_busy_flag <= 1'b0;
              conversion_trigger   <= 1'b0;
              state                <= TSC_IDLE;
            end else begin
              cmp_code <= cmp_code + 8'h01;
              step_cnt <= step_compare_period;
            end
          end
          default: state <= TSC_IDLE;
        endcase
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  always_comb begin
    irq_evt                   = '0;
    irq_evt[TSC_IRQ_DONE_BIT] = done_evt;
  end

  for (genvar gi = 0; gi < TSC_IRQ_W; gi++) begin : g_irq_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        irq_status[gi] <= 1'b0;
      end else if (clk_en) begin
        irq_status[gi] <= irq_evt[gi] ||
                          (irq_status[gi] && !(wr_iclr && w_data[gi]));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // AXI4-Lite read side.
  always_comb begin
    next_rdata = TSC_ZERO32;
    next_rresp = TSC_RESP_OKAY;
    case (s_axi_araddr)
      TSC_OFF_CLK: begin
        next_rdata[TSC_CLK_SRC_LSB +: 2] = thermal_clk_source_sel;
        next_rdata[TSC_CLK_DIV_LSB +: 2] = thermal_clk_divider_sel;
        next_rdata[TSC_CLK_GATE_BIT]     = thermal_clk_gate_en;
      end
      TSC_OFF_CTL: begin
        next_rdata[TSC_CTL_TRIG_BIT]   = conversion_trigger;
        next_rdata[TSC_CTL_SENSOR_BIT] = sensor_power_on;
      end
      TSC_OFF_TIME: next_rdata[7:0] = step_compare_period;
      TSC_OFF_STAT: begin
        next_rdata[TSC_STAT_BUSY_BIT]  = conversion_busy_flag;
        next_rdata[TSC_STAT_VALID_BIT] = result_valid;
      end
      TSC_OFF_RSLT: next_rdata[CODE_W-1:0]    = result_code;
      TSC_OFF_IFLG: next_rdata[TSC_IRQ_W-1:0] = irq_status;
      TSC_OFF_ICLR: next_rdata = TSC_ZERO32;
      TSC_OFF_IEN:  next_rdata[TSC_IRQ_W-1:0] = irq_enable;
      default:      next_rresp = TSC_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= TSC_ZERO32;
      s_axi_rresp   <= TSC_RESP_OKAY;
    end else if (clk_en) begin
      // Read data is captured at the address handshake and stands until rready.
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // tsc_top
`default_nettype wire

/* verification/tsc_properties.sv */
// Purpose: Port level checks bound to every tsc_top instance.
// Assumes: clk_en stays high, oscillator ticks are aclk synchronous.
// Notes:   Watches only ports; register contents are judged by the bench.
`default_nettype none
module tsc_properties
  import tsc_pkg::*;
#(
  parameter int CODE_W = 8
) (
  // Clock and reset.
  input wire logic              aclk,
  input wire logic              aresetn,
  // Ticks and sensor.
  input wire logic              fast_osc_a,
  input wire logic              fast_osc_b,
  input wire logic              slow_osc_32k,
  input wire logic              sensor_power_on,
  input wire logic [CODE_W-1:0] cmp_code,
  // Bus handshakes.
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Interrupt.
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_hist;
  logic [3:0] since_aw;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A tick reaches the code register through the registered operating clock,
  // so the code may move only exactly two cycles after some oscillator tick.
  always_ff @(posedge aclk) begin
    tick_hist <= {tick_hist[0], fast_osc_a | fast_osc_b | slow_osc_32k};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_aw <= 4'hf;
    end else if (s_axi_awvalid && s_axi_awready) begin
      since_aw <= 4'h0;
    end else if (since_aw != 4'hf) begin
      since_aw <= since_aw + 4'h1;
    end
  end
  chk_aw_pulse: assert property (s_axi_awready |-> $past(s_axi_awvalid) ##1 !s_axi_awready)
    else $error("write address ready misbehaved");
  chk_b_follows: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_code_step: assert property (
    $changed(cmp_code) |-> cmp_code == $past(cmp_code) + 1'b1 || cmp_code == {CODE_W{1'b0}})
    else $error("code moved by other than one step");
  chk_code_tick: assert property ($changed(cmp_code) |-> tick_hist[1])
    else $error("code moved without an operating clock tick");
  chk_irq_clear: assert property ($fell(irq) |-> since_aw <= 4'h6)
    else $error("interrupt dropped without a register write");
  chk_power_write: assert property ($changed(sensor_power_on) |-> since_aw <= 4'h4)
    else $error("sensor power changed without a register write");
  cover property ($rose(irq));
  cover property (&cmp_code);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // tsc_properties
bind tsc_top tsc_properties #(.CODE_W(CODE_W)) u_tsc_chk (.*);
`default_nettype wire

/* verification/tsc_sensor_model.sv */
// Purpose: Behavioural analog sensor and comparator.
// Assumes: Settling time is scaled down to SETTLE aclk cycles.
// Notes:   Target 0x100 never matches, to force a full sweep.
`default_nettype none
module tsc_sensor_model #(
  parameter int SETTLE = 20
) (
  input wire logic       aclk,
  input wire logic       power_on,
  input wire logic [7:0] code,
  input wire logic [8:0] target,
  output logic           match
);
  timeunit 1ns;
  timeprecision 1ps;
  int settled = 0;
  always_ff @(posedge aclk) begin
    if (!power_on) settled <= 0;
    else if (settled < SETTLE) settled <= settled + 1;
  end
  // An unsettled sensor wanders, so an early trigger gets junk.
  assign match = !power_on ? 1'b0 : (settled < SETTLE) ? settled[0] : ({1'b0, code} == target);
endmodule // tsc_sensor_model
`default_nettype wire

/* verification/thermal_sense_conversion_tb.sv */
// Purpose: Self-checking bench for tsc_top.
// Assumes: Tick periods 3 (fast B), 7 (slow), 2 (fast A) cycles.
// Notes:   Each scenario task judges its own results.
`default_nettype none
module thermal_sense_conversion_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tsc_pkg::*;
  localparam int SETTLE = 20;
  logic aclk = 0, aresetn = 0, clk_en = 1, cmp_match, irq, sensor_power_on;
  logic fast_osc_a = 0, fast_osc_b = 0, slow_osc_32k = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [TSC_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]       s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]        cmp_code;
  logic [8:0]        target = 0;
  int                failures = 0, n_checks = 0, cnt = 0;
  tsc_top i_dut (.*);
  tsc_sensor_model #(.SETTLE(SETTLE)) i_sensor (.aclk(aclk), .power_on(sensor_power_on),
    .code(cmp_code), .target(target), .match(cmp_match));
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cnt <= cnt + 1;
    fast_osc_b <= (cnt % 3 == 0);
    slow_osc_32k <= (cnt % 7 == 0);
    fast_osc_a <= (cnt % 2 == 0);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("ERROR t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout();
    check(32'h0000_0000, 32'h0000_0001);
    complete_run();
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 64) timeout();
    rsp = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [4:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 64) timeout();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic wait_code(input logic [7:0] v);
    int k;
    for (k = 0; k < 4000 && cmp_code !== v; k++) @(posedge aclk);
    if (k == 4000) timeout();
  endtask
  // Only call once busy has been seen, since busy rises on the first tick.
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400; k++) begin
      axi_rd(TSC_OFF_STAT);
      if (rd[0] === 1'b0) break;
    end
    if (k == 400) timeout();
  endtask
  task automatic t_regs();
    logic [4:0] offs [5] = '{TSC_OFF_CLK, TSC_OFF_TIME, TSC_OFF_STAT, TSC_OFF_IEN, TSC_OFF_ICLR};
    foreach (offs[i]) begin
      axi_rd(offs[i]);
      check(rd, TSC_ZERO32);
    end
    axi_wr(5'h1e, 32'h0000_0001);
    check(rsp, TSC_RESP_SLVERR);
    axi_rd(5'h1e);
    check(rsp, TSC_RESP_SLVERR);
    axi_wr(TSC_OFF_STAT, 32'h0000_0003);
    axi_rd(TSC_OFF_STAT);
    check(rd, TSC_ZERO32);
  endtask
  task automatic t_conv(input logic [1:0] src, input logic [1:0] div, input logic [7:0] n,
                        input logic [7:0] tgt, input int p);
    int c;
    axi_wr(TSC_OFF_CLK, {27'h000_0000, 1'b1, div, src});
    axi_wr(TSC_OFF_TIME, {24'h00_0000, n});
    axi_wr(TSC_OFF_IEN, 32'h0000_0001);
    target <= {1'b0, tgt};
    axi_wr(TSC_OFF_CTL, 32'h0000_0003);
    wait_code(8'h01);
    for (c = 0; c < 4000 && cmp_code === 8'h01; c++) @(posedge aclk);
    if (c == 4000) timeout();
    check(c, (n + 1) * p);
    check(cmp_code, 8'h02);
    axi_rd(TSC_OFF_STAT);
    check(rd[0], 1'b1);
    wait_idle();
    axi_rd(TSC_OFF_RSLT);
    check(rd, {24'h00_0000, tgt});
    axi_rd(TSC_OFF_STAT);
    check(rd, 32'h0000_0002);
    check(irq, 1'b1);
    repeat (50) @(posedge aclk);
    check(cmp_code, tgt);
    axi_wr(TSC_OFF_ICLR, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
  endtask
  task automatic t_overrun();
    target <= 9'h100;
    axi_wr(TSC_OFF_CLK, 32'h0000_0010);
    axi_wr(TSC_OFF_TIME, TSC_ZERO32);
    axi_wr(TSC_OFF_IEN, TSC_ZERO32);
    axi_wr(TSC_OFF_CTL, 32'h0000_0003);
    wait_code(8'h05);
    wait_idle();
    axi_rd(TSC_OFF_RSLT);
    check(rd, 32'h0000_00ff);
    axi_rd(TSC_OFF_IFLG);
    check(rd, 32'h0000_0001);
    check(irq, 1'b0);
    axi_wr(TSC_OFF_IEN, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    check(irq, 1'b1);
    axi_wr(TSC_OFF_ICLR, 32'h0000_0001);
  endtask
  task automatic t_abort();
    target <= 9'h0c8;
    axi_wr(TSC_OFF_TIME, 32'h0000_0002);
    axi_wr(TSC_OFF_CTL, 32'h0000_0003);
    wait_code(8'h02);
    axi_wr(TSC_OFF_CTL, 32'h0000_0002);
    axi_rd(TSC_OFF_STAT);
    check(rd, TSC_ZERO32);
    repeat (40) @(posedge aclk);
    axi_rd(TSC_OFF_IFLG);
    check(rd, TSC_ZERO32);
    check(irq, 1'b0);
  endtask
  task automatic t_no_clock(input logic [31:0] clk_val);
    logic [7:0] held;
    axi_wr(TSC_OFF_CLK, clk_val);
    held = cmp_code;
    axi_wr(TSC_OFF_CTL, 32'h0000_0003);
    repeat (100) @(posedge aclk);
    check(cmp_code, held);
    axi_rd(TSC_OFF_STAT);
    check(rd[0], 1'b0);
    axi_wr(TSC_OFF_CTL, 32'h0000_0002);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    axi_wr(TSC_OFF_CTL, 32'h0000_0002);
    repeat (SETTLE + 2) @(posedge aclk);
    check(sensor_power_on, 1'b1);
    t_conv(TSC_SRC_FAST_B, 2'h0, 8'h02, 8'h03, 3);
    t_conv(TSC_SRC_SLOW, 2'h3, 8'h00, 8'h04, 7);
    t_conv(TSC_SRC_FAST_A, 2'h2, 8'h01, 8'h03, 8);
    t_conv(TSC_SRC_FAST_A, 2'h1, 8'h00, 8'h03, 4);
    t_conv(TSC_SRC_FAST_B, 2'h3, 8'h00, 8'h03, 24);
    t_overrun();
    t_abort();
    t_no_clock(32'h0000_0000);
    t_no_clock(32'h0000_0013);
    axi_wr(TSC_OFF_CLK, TSC_ZERO32);
    complete_run();
  end
endmodule // thermal_sense_conversion_tb
`default_nettype wire
